// >>> design/sssfc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Status lamps, fault latch and safe output control of the gate switch.
module sssfc_top #(
  parameter int unsigned ON_DELAY_CYC = sssfc_pkg::ON_DELAY_CYC,
  parameter int unsigned LOSS_CYC     = sssfc_pkg::LOSS_CYC,
  parameter int unsigned TEST_GAP_CYC = sssfc_pkg::TEST_GAP_CYC,
  parameter int unsigned PARTIAL_CYC  = sssfc_pkg::PARTIAL_CYC,
  parameter int unsigned SHORT_CYC    = sssfc_pkg::SHORT_CYC,
  parameter int unsigned DIGIT_CYC    = sssfc_pkg::DIGIT_CYC,
  parameter int unsigned PAUSE_CYC    = sssfc_pkg::PAUSE_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       actuator_i,
  input  wire logic [1:0] input_ch_i,
  input  wire logic       supply_voltage_ok_i,
  input  wire logic [1:0] safe_switching_output_sense_i,
  output logic [1:0]      safe_switching_output_o,
  output logic            lamp_green_o,
  output logic            lamp_red_o,
  output logic            lamp_gate_o,
  output logic            lamp_input_o
);
  // Every outside input except srst_i passes two flip-flops first.
  logic       act_m_q, act_q, sup_m_q, sup_q;
  logic [1:0] in_m_q, in_q, sns_m_q, sns_q;
  always_ff @(posedge clk_i) begin
    act_m_q <= actuator_i;
    act_q   <= act_m_q;
    in_m_q  <= input_ch_i;
    in_q    <= in_m_q;
    sup_m_q <= supply_voltage_ok_i;
    sup_q   <= sup_m_q;
    sns_m_q <= safe_switching_output_sense_i;
    sns_q   <= sns_m_q;
  end

  // Switch-on delay; a fault on the sense lines here means outside voltage.
  logic [31:0] on_tmr_q;
  logic        ready_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      on_tmr_q <= 32'h0;
      ready_q  <= 1'b0;
    end else if (!ready_q) begin
      if (on_tmr_q == ON_DELAY_CYC - 1) begin
        ready_q <= 1'b1;
      end else begin
        on_tmr_q <= on_tmr_q + 32'h1;
      end
    end
  end

  // Input supply loss filter: sustained loss drops the outputs.
  logic [31:0] loss_tmr_q;
  logic        lost_q;
  always_ff @(posedge clk_i) begin
    if (srst_i || sup_q) begin
      loss_tmr_q <= 32'h0;
      lost_q     <= 1'b0;
    end else if (loss_tmr_q == LOSS_CYC - 1) begin
      lost_q <= 1'b1;
    end else begin
      loss_tmr_q <= loss_tmr_q + 32'h1;
    end
  end

  // Partial operation: one channel fell while the other stayed high.
  // No time window applies to the two channels, so nothing times out.
  logic [1:0] in_prev_q;
  logic       partial_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      in_prev_q <= 2'h0;
      partial_q <= 1'b0;
    end else begin
      in_prev_q <= in_q;
      if (in_q == 2'h0) begin
        partial_q <= 1'b0;
      end else if ((in_prev_q == 2'h3) && (in_q != 2'h3)) begin
        partial_q <= 1'b1;
      end
    end
  end

  // Safe outputs are requested on when ready, supply not lost, no partial operation latched, both input channels high and actuator present.
  logic enable_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= ready_q && !lost_q && act_q && (in_q == 2'h3) &&
                  !partial_q;
    end
  end

  // Test pulse generator: alternates a pulse on each output.
  logic [31:0] tp_tmr_q;
  logic        tp_act_q;
  logic        tp_sel_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tp_tmr_q <= 32'h0;
      tp_act_q <= 1'b0;
      tp_sel_q <= 1'b0;
    end else if (tp_act_q) begin
      if (tp_tmr_q == sssfc_pkg::TEST_CYC - 1) begin
        tp_act_q <= 1'b0;
        tp_tmr_q <= 32'h0;
        tp_sel_q <= ~tp_sel_q;
      end else begin
        tp_tmr_q <= tp_tmr_q + 32'h1;
      end
    end else if (tp_tmr_q == TEST_GAP_CYC - 1) begin
      tp_act_q <= 1'b1;
      tp_tmr_q <= 32'h0;
    end else begin
      tp_tmr_q <= tp_tmr_q + 32'h1;
    end
  end

  // Fault latch is cleared only by reset, i.e. a power cycle.
  logic        fault_q;
  logic [15:0] code_q;
  logic [2:0]  len_q;
  logic [1:0]  drv1_q;
  logic [1:0]  drv2_q;
  logic [1:0]  held_on;
  logic [1:0]  held_off;

  // Drive history lined up with the two-stage sense sync. A bit is judged
  // only once it held for two cycles, so edges and test pulses never look
  // like a short; the check adds no detection latency beyond the two-cycle sync.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      drv1_q <= 2'h0;
      drv2_q <= 2'h0;
    end else begin
      drv1_q <= safe_switching_output_o;
      drv2_q <= drv1_q;
    end
  end
  assign held_on  = drv1_q & drv2_q;
  assign held_off = ~(drv1_q | drv2_q);

  // Only the first fault is latched, so its code is never overwritten.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fault_q <= 1'b0;
      code_q  <= 16'h0;
      len_q   <= 3'h0;
    end else if (!fault_q) begin
      if (!ready_q && (sns_q != 2'h0) && (on_tmr_q > 32'h2)) begin
        fault_q <= 1'b1;
        code_q  <= sssfc_pkg::CODE_STARTUP;
        len_q   <= sssfc_pkg::LEN_STARTUP;
      end else if (ready_q && held_on[0] && !sns_q[0]) begin
        fault_q <= 1'b1;
        code_q  <= sssfc_pkg::CODE_LOW1;
        len_q   <= sssfc_pkg::LEN_LOW;
      end else if (ready_q && held_on[1] && !sns_q[1]) begin
        fault_q <= 1'b1;
        code_q  <= sssfc_pkg::CODE_LOW2;
        len_q   <= sssfc_pkg::LEN_LOW;
      end else if (ready_q && enable_q && held_off[0] && sns_q[0] &&
                   tp_act_q && !tp_sel_q) begin
        fault_q <= 1'b1;
        code_q  <= sssfc_pkg::CODE_HIGH1;
        len_q   <= sssfc_pkg::LEN_HIGH;
      end else if (ready_q && enable_q && held_off[1] && sns_q[1] &&
                   tp_act_q && tp_sel_q) begin
        fault_q <= 1'b1;
        code_q  <= sssfc_pkg::CODE_HIGH2;
        len_q   <= sssfc_pkg::LEN_HIGH;
      end
    end
  end

  // Drive with the test pulse cut into one output at a time.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      safe_switching_output_o <= 2'h0;
    end else if (enable_q && !fault_q) begin
      safe_switching_output_o[0] <= !(tp_act_q && !tp_sel_q);
      safe_switching_output_o[1] <= !(tp_act_q && tp_sel_q);
    end else begin
      safe_switching_output_o <= 2'h0;
    end
  end

  // Partial-operation blink timer.
  logic [31:0] blink_tmr_q;
  logic        blink_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      blink_tmr_q <= 32'h0;
      blink_q     <= 1'b0;
    end else if (blink_tmr_q == PARTIAL_CYC - 1) begin
      blink_tmr_q <= 32'h0;
      blink_q     <= ~blink_q;
    end else begin
      blink_tmr_q <= blink_tmr_q + 32'h1;
    end
  end

  logic flash;
  sssfc_flasher #(
    .SHORT_CYC (SHORT_CYC),
    .DIGIT_CYC (DIGIT_CYC),
    .PAUSE_CYC (PAUSE_CYC)
  ) u_flasher (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .run_i  (fault_q),
    .code_i (code_q),
    .len_i  (len_q),
    .lamp_o (flash)
  );

  // Lamp drivers; under a fault both gate and input lamps show the code.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lamp_green_o <= 1'b0;
      lamp_red_o   <= 1'b0;
      lamp_gate_o  <= 1'b0;
      lamp_input_o <= 1'b0;
    end else begin
      lamp_green_o <= ready_q && !fault_q;
      lamp_red_o   <= fault_q;
      if (fault_q) begin
        lamp_gate_o  <= flash;
        lamp_input_o <= flash;
      end else begin
        lamp_gate_o  <= act_q;
        lamp_input_o <= partial_q ? blink_q : (in_q == 2'h3);
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/sssfc_pkg.sv
`default_nettype none
package sssfc_pkg;
  localparam int unsigned CLK_HZ       = 40000000;
  localparam int unsigned TEST_US      = 450;
  localparam int unsigned TEST_CYC     = (CLK_HZ / 1000000) * TEST_US;
  localparam int unsigned ON_DELAY_MS  = 1000;
  localparam int unsigned ON_DELAY_CYC = (CLK_HZ / 1000) * ON_DELAY_MS;
  localparam int unsigned LOSS_MS      = 10;
  localparam int unsigned LOSS_CYC     = (CLK_HZ / 1000) * LOSS_MS;
  localparam int unsigned TEST_GAP_MS  = 100;
  localparam int unsigned TEST_GAP_CYC = (CLK_HZ / 1000) * TEST_GAP_MS;
  localparam int unsigned DIGIT_MS     = 1000;
  localparam int unsigned DIGIT_CYC    = (CLK_HZ / 1000) * DIGIT_MS;
  localparam int unsigned SHORT_MS     = 150;
  localparam int unsigned SHORT_CYC    = (CLK_HZ / 1000) * SHORT_MS;
  localparam int unsigned PAUSE_MS     = 2000;
  localparam int unsigned PAUSE_CYC    = (CLK_HZ / 1000) * PAUSE_MS;
  localparam int unsigned PARTIAL_MS   = 250;
  localparam int unsigned PARTIAL_CYC  = (CLK_HZ / 1000) * PARTIAL_MS;
  localparam int unsigned CNT_W        = 32;
  localparam int unsigned PREAMBLE_N   = 3;
  // Fault codes: four nibbles, first digit in the top nibble.
  localparam logic [15:0] CODE_STARTUP = 16'h141f;
  localparam logic [15:0] CODE_LOW1    = 16'h1cff;
  localparam logic [15:0] CODE_LOW2    = 16'h1dff;
  localparam logic [15:0] CODE_HIGH1   = 16'heff_f;
  localparam logic [15:0] CODE_HIGH2   = 16'hffff;
  localparam logic [2:0]  LEN_STARTUP  = 3'h3;
  localparam logic [2:0]  LEN_LOW      = 3'h2;
  localparam logic [2:0]  LEN_HIGH     = 3'h1;
endpackage
`default_nettype wire

// >>> design/sssfc_flasher.sv
`timescale 1ns/1ps
`default_nettype none
// Flash code sequencer: preamble of short flashes, then up to four digits.
module sssfc_flasher #(
  parameter int unsigned SHORT_CYC = sssfc_pkg::SHORT_CYC,
  parameter int unsigned DIGIT_CYC = sssfc_pkg::DIGIT_CYC,
  parameter int unsigned PAUSE_CYC = sssfc_pkg::PAUSE_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        run_i,
  input  wire logic [15:0] code_i,
  input  wire logic [2:0]  len_i,
  output logic             lamp_o
);
  typedef enum logic [2:0] {
    SSSFC_IDLE, SSSFC_PRE_ON, SSSFC_PRE_OFF, SSSFC_PAUSE,
    SSSFC_DIG_ON, SSSFC_DIG_OFF, SSSFC_GAP
  } sssfc_fl_e;

  sssfc_fl_e   state_q;
  logic [31:0] tmr_q;
  logic [4:0]  cnt_q;
  logic [2:0]  dig_q;

  // Zero digit is sent as sixteen flashes.
  function automatic logic [4:0] flashes(input logic [15:0] c,
                                         input logic [2:0] i);
    logic [3:0] n;
    n = c[15 - 4 * i -: 4];
    flashes = (n == 4'h0) ? 5'h10 : {1'b0, n};
  endfunction

  // Each interval lives in tmr_q; on expiry the next phase is loaded.
  always_ff @(posedge clk_i) begin
    if (srst_i || !run_i) begin
      state_q <= SSSFC_IDLE;
      tmr_q   <= 32'h0;
      cnt_q   <= 5'h0;
      dig_q   <= 3'h0;
      lamp_o  <= 1'b0;
    end else if (tmr_q != 32'h0) begin
      tmr_q <= tmr_q - 32'h1;
    end else begin
      case (state_q)
        SSSFC_IDLE, SSSFC_GAP: begin
          if (state_q == SSSFC_IDLE || dig_q == len_i) begin
            state_q <= SSSFC_PRE_ON;
            cnt_q   <= 5'(sssfc_pkg::PREAMBLE_N);
            dig_q   <= 3'h0;
            lamp_o  <= 1'b1;
            tmr_q   <= SHORT_CYC - 1;
          end else begin
            state_q <= SSSFC_DIG_ON;
            cnt_q   <= flashes(code_i, dig_q);
            lamp_o  <= 1'b1;
            tmr_q   <= DIGIT_CYC / 2 - 1;
          end
        end
        SSSFC_PRE_ON: begin
          state_q <= SSSFC_PRE_OFF;
          lamp_o  <= 1'b0;
          tmr_q   <= SHORT_CYC - 1;
          cnt_q   <= cnt_q - 5'h1;
        end
        SSSFC_PRE_OFF: begin
          if (cnt_q != 5'h0) begin
            state_q <= SSSFC_PRE_ON;
            lamp_o  <= 1'b1;
            tmr_q   <= SHORT_CYC - 1;
          end else begin
            state_q <= SSSFC_PAUSE;
            tmr_q   <= PAUSE_CYC - 1;
          end
        end
        SSSFC_PAUSE: begin
          state_q <= SSSFC_DIG_ON;
          cnt_q   <= flashes(code_i, 3'h0);
          lamp_o  <= 1'b1;
          tmr_q   <= DIGIT_CYC / 2 - 1;
        end
        SSSFC_DIG_ON: begin
          state_q <= SSSFC_DIG_OFF;
          lamp_o  <= 1'b0;
          tmr_q   <= DIGIT_CYC / 2 - 1;
          cnt_q   <= cnt_q - 5'h1;
        end
        SSSFC_DIG_OFF: begin
          if (cnt_q != 5'h0) begin
            state_q <= SSSFC_DIG_ON;
            lamp_o  <= 1'b1;
            tmr_q   <= DIGIT_CYC / 2 - 1;
          end else begin
            state_q <= SSSFC_GAP;
            dig_q   <= dig_q + 3'h1;
            tmr_q   <= PAUSE_CYC - 1;
          end
        end
        default: state_q <= SSSFC_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> bench/sssfc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the green, red and gate lamps and safe outputs of the status block from its pins.
module sssfc_monitor #(
  parameter int unsigned ON_DELAY_CYC = 200,
  parameter int unsigned LOSS_CYC     = 20
) (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       actuator_i,
  input wire logic [1:0] input_ch_i,
  input wire logic       supply_voltage_ok_i,
  input wire logic [1:0] safe_switching_output_o,
  input wire logic       lamp_green_o,
  input wire logic       lamp_red_o,
  input wire logic       lamp_gate_o
);
  logic [31:0] up_q;
  logic [31:0] loss_q;

  // Cycles since reset release, saturating so long runs never wrap.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      up_q <= '0;
    end else if (up_q != 32'hffffffff) begin
      up_q <= up_q + 32'h1;
    end
  end

  // Cycles without input supply; raw pin, so the design's sync adds slack.
  always_ff @(posedge clk_i) begin
    if (srst_i || supply_voltage_ok_i) begin
      loss_q <= '0;
    end else if (loss_q != 32'hffffffff) begin
      loss_q <= loss_q + 32'h1;
    end
  end

  default clocking dc @(posedge clk_i); endclocking
  default disable iff (srst_i);

  AST_ON_DELAY: assert property (
    up_q < ON_DELAY_CYC |-> safe_switching_output_o == 2'h0)
    else $error("safe output on inside switch-on delay");
  AST_GREEN_DELAY: assert property (
    up_q < ON_DELAY_CYC |-> !lamp_green_o)
    else $error("green lamp before ready");
  AST_LAMP_EXCL: assert property (
    !(lamp_green_o && lamp_red_o))
    else $error("green and red together");
  AST_FAULT_HELD: assert property (
    lamp_red_o |=> lamp_red_o)
    else $error("fault released without power cycle");
  AST_FAULT_OFF: assert property (
    lamp_red_o [*2] |-> safe_switching_output_o == 2'h0)
    else $error("safe output on while fault latched");
  AST_SUPPLY_LOSS: assert property (
    loss_q >= LOSS_CYC + 4 |-> safe_switching_output_o == 2'h0)
    else $error("safe output on after supply loss");
  AST_INPUTS_OPEN: assert property (
    (input_ch_i != 2'h3) [*5] |-> safe_switching_output_o == 2'h0)
    else $error("safe output on with an input open");
  AST_GATE_ON: assert property (
    (!lamp_red_o && actuator_i) [*5] |-> lamp_gate_o)
    else $error("gate lamp dark with actuator present");
  AST_GATE_OFF: assert property (
    (!lamp_red_o && !actuator_i) [*5] |-> !lamp_gate_o)
    else $error("gate lamp lit without actuator");
  AST_FLASH_START: assert property (
    $rose(lamp_red_o) |-> ##[0:40] lamp_gate_o)
    else $error("no flash after fault");
endmodule

bind sssfc_top sssfc_monitor u_mon (
  .clk_i(clk_i), .srst_i(srst_i), .actuator_i(actuator_i),
  .input_ch_i(input_ch_i), .supply_voltage_ok_i(supply_voltage_ok_i),
  .safe_switching_output_o(safe_switching_output_o),
  .lamp_green_o(lamp_green_o), .lamp_red_o(lamp_red_o),
  .lamp_gate_o(lamp_gate_o)
);
`default_nettype wire

// >>> bench/sssfc_eval_model.sv
`timescale 1ns/1ps
`default_nettype none
// Evaluation device and wiring on the safe outputs, with injectable shorts.
module sssfc_eval_model (
  input  wire logic [1:0] out_i,
  input  wire logic [1:0] short_low_i,
  input  wire logic [1:0] short_high_i,
  output logic [1:0]      sense_o
);
  // Read-back follows the wire, test pulses included; an applied voltage
  // beats a short to 0 V, as a stiff supply would.
  always_comb begin
    sense_o = (out_i & ~short_low_i) | short_high_i;
  end
endmodule
`default_nettype wire

// >>> bench/test_safety_switch_status_flash_code.sv
`timescale 1ns/1ps
`default_nettype none
module test_safety_switch_status_flash_code;
  localparam int unsigned OND = 200;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        act = 1'b0;
  logic [1:0]  ch = 2'h0;
  logic        sup = 1'b1;
  logic [1:0]  s_lo = 2'h0;
  logic [1:0]  s_hi = 2'h0;
  logic [1:0]  sense;
  logic [1:0]  outs;
  logic        green, red, gate, inp, gate_q = 1'b0, j;
  logic [15:0] codes [4] = '{16'h1c00, 16'h1d00, 16'he000, 16'hf000};
  int          nfl = 0, dark = 0, exp_v, i, k, cycles = 0;
  int          n_fail = 0;
  int          n_tests = 0;
  int          exp_q [$];
  int unsigned seed;

  sssfc_top #(.ON_DELAY_CYC(OND), .LOSS_CYC(20), .TEST_GAP_CYC(300),
    .PARTIAL_CYC(10), .SHORT_CYC(4), .DIGIT_CYC(8), .PAUSE_CYC(16)) dut (
    .clk_i(clk_i), .srst_i(srst_i), .actuator_i(act), .input_ch_i(ch),
    .supply_voltage_ok_i(sup), .safe_switching_output_sense_i(sense),
    .safe_switching_output_o(outs), .lamp_green_o(green),
    .lamp_red_o(red), .lamp_gate_o(gate), .lamp_input_o(inp));
  sssfc_eval_model u_eval (.out_i(outs), .short_low_i(s_lo),
    .short_high_i(s_hi), .sense_o(sense));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests != 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // The first group after a fault may be cut short, so it is skipped.
  task automatic expect_code(input logic [15:0] code, input int len);
    logic [3:0] d;
    exp_q.push_back(0);
    for (int r = 0; r < 2; r++) begin
      if (r != 0) exp_q.push_back(3);
      for (int n = 0; n < len; n++) begin
        d = code[15 - 4 * n -: 4];
        exp_q.push_back((d == 4'h0) ? 16 : int'(d));
      end
    end
  endtask

  task automatic drain();
    for (int w = 0; w < 40000 && exp_q.size() != 0; w++) tick(1);
    check(32'(exp_q.size()), 0);
    check(32'(inp), 32'(gate));
    check(32'(green), 0);
  endtask

  task automatic power_up(input logic [1:0] hi);
    @(posedge clk_i);
    srst_i <= 1'b1;
    act <= 1'b0;
    ch <= 2'h0;
    s_lo <= 2'h0;
    s_hi <= hi;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    tick(OND + 10);
  endtask

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // Counts flashes per group; a long dark run closes a group.
  always @(posedge clk_i) begin
    gate_q <= gate;
    dark <= gate ? 0 : dark + 1;
    if (srst_i || !red) nfl <= 0;
    else if (gate && !gate_q) nfl <= nfl + 1;
    if (dark == 12 && nfl != 0 && exp_q.size() != 0) begin
      exp_v = exp_q.pop_front();
      if (exp_v != 0) check(nfl, exp_v);
      nfl <= 0;
    end
  end

  // Hang guard sized well above the longest pulse waits.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    seed = $urandom(32'haf11443f);
    expect_code(16'h1410, 3);
    power_up(2'h1);
    drain();
    power_up(2'h0);
    check(32'(green), 1);
    @(posedge clk_i) ch <= 2'(1 << ($urandom % 2));
    tick(50 + $urandom % 250);
    @(posedge clk_i) ch <= 2'h3;
    act <= 1'b1;
    tick(10);
    check(32'(gate), 1);
    check(32'(inp), 1);
    check(32'(red), 0);
    for (i = 0; i < 20000 && outs !== 2'h3; i++) tick(1);
    for (i = 0; i < 20000 && outs === 2'h3; i++) tick(1);
    for (k = 0; k < 20000 && outs !== 2'h3; k++) tick(1);
    check(k, sssfc_pkg::TEST_CYC);
    @(posedge clk_i) ch <= 2'(2 >> ($urandom % 2));
    tick(30);
    j = inp;
    k = 0;
    for (i = 0; i < 60; i++) begin
      tick(1);
      if (inp !== j) k++;
      j = inp;
    end
    check(32'(k >= 4), 1);
    @(posedge clk_i) ch <= 2'h3;
    tick(20);
    check(32'(outs), 0);
    @(posedge clk_i) ch <= 2'h0;
    tick(10);
    @(posedge clk_i) ch <= 2'h3;
    tick(10);
    check(32'(inp), 1);
    @(posedge clk_i) sup <= 1'b0;
    tick(30);
    check(32'(outs), 0);
    @(posedge clk_i) sup <= 1'b1;
    for (i = 0; i < 4; i++) begin
      power_up(2'h0);
      @(posedge clk_i) ch <= 2'h3;
      act <= 1'b1;
      tick(20);
      @(posedge clk_i) s_lo <= (i < 2) ? 2'(1 << i) : 2'h0;
      s_hi <= (i > 1) ? 2'(1 << (i - 2)) : 2'h0;
      expect_code(codes[i], (i < 2) ? 2 : 1);
      drain();
      @(posedge clk_i) s_lo <= 2'h0;
      s_hi <= 2'h0;
      tick(5);
      check(32'(red), 1);
    end
    stop_test();
  end
endmodule
`default_nettype wire
